//--- core/audio_serial_slot_mapper.sv
// Slot mapper for channels 1 and 2 of the audio serial output, Wishbone registers
// Assumes bclk_i and fsync_i come from the host; channel words from clk_i logic
// Function
// - Ch1 line bit picks primary/secondary pin
// - Ch2 line bit picks primary/secondary pin
// - Codes 0-31: TDM slot or left slot
// - Codes 32-63: TDM slot or right slot
// - Ch1 register at 0xB, resets zero
// - Ch2 register at 0xC, resets 0x1
// - Bit 7 reads zero, write reset value
// - Middle codes map linearly, one slot each
// - Slot-0 offset delays MSB by bit clocks
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module audio_serial_slot_mapper
   import slot_map_pkg::*;
#(
   parameter int SLOT_W = 32,
   parameter int ADR_W  = 8
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [ADR_W-1:0]  adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   // Channel samples
   input  wire logic [SLOT_W-1:0] chan1_data_i,
   input  wire logic [SLOT_W-1:0] chan2_data_i,
   // Link from host
   input  wire logic              bclk_i,
   input  wire logic              fsync_i,
   // Serial outputs
   output logic                   primary_serial_out_o,
   output logic                   primary_oe_o,
   output logic                   secondary_serial_out_o,
   output logic                   secondary_oe_o
);
   localparam int SLOT_LG = $clog2(SLOT_W);
   localparam int CNT_W   = $clog2(ALL_SLOTS * SLOT_W + 64) + 1;
   localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

   // Refuse sizes that the slot and address logic cannot serve
   if (SLOT_W < 8 || SLOT_W > 32 || (1 << SLOT_LG) != SLOT_W) begin : g_bad_slot_w
      $error("SLOT_W must be a power of two from 8 to 32");
   end
   if (ADR_W < 8) begin : g_bad_adr_w
      $error("ADR_W must be at least 8");
   end

   function automatic logic hits(input logic [6:0] cfg, input logic line,
                                 input logic [5:0] slot);
      hits = (cfg[LINE_BIT] == line) && (cfg[SLOT_HI:0] == slot);
   endfunction : hits

   // Link synchronisers
   logic bclk_s1_q;
   logic bclk_s2_q;
   logic bclk_prev_q;
   logic fs_s1_q;
   logic fs_s2_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bclk_s1_q   <= 1'b0;
         bclk_s2_q   <= 1'b0;
         bclk_prev_q <= 1'b0;
         fs_s1_q     <= 1'b0;
         fs_s2_q     <= 1'b0;
      end else begin
         bclk_s1_q   <= bclk_i;
         bclk_s2_q   <= bclk_s1_q;
         bclk_prev_q <= bclk_s2_q;
         fs_s1_q     <= fsync_i;
         fs_s2_q     <= fs_s1_q;
      end
   end
   logic bclk_fall;
   assign bclk_fall = bclk_prev_q & ~bclk_s2_q;

   // Registers
   logic [6:0] ch1_q, ch1_d;
   logic [6:0] ch2_q, ch2_d;
   logic [6:0] frm_q, frm_d;
   logic       conf_q, conf_d, ack_d;
   logic [31:0] dat_d;
   logic [5:0] idx;
   logic       wr_lane;
   fmt_t       fmt;
   logic [4:0] ofs;
   assign idx     = adr_i[7:2];
   assign wr_lane = cyc_i & stb_i & we_i & ack_o & sel_i[0];
   assign fmt     = fmt_t'(frm_q[FMT_HI:0]);
   assign ofs     = frm_q[OFS_HI:OFS_LO];

   // Frame engine state
   logic [CNT_W-1:0]  cnt_q, cnt_d, dly, pos;
   logic              fs_last_q, fs_last_d, right_d, right_q;
   logic [SLOT_W-1:0] d1_q, d1_d, d2_q, d2_d;
   logic [5:0]        cur_q, cur_d, slot;
   logic              p_out_d, p_oe_d, s_out_d, s_oe_d;
   logic              live, clash, frame_start;
   logic [1:0]        h1, h2;
   logic              b1, b2;

   always_comb begin
      cnt_d     = cnt_q;
      fs_last_d = fs_last_q;
      right_d   = right_q;
      d1_d      = d1_q;
      d2_d      = d2_q;
      cur_d     = cur_q;
      p_out_d   = primary_serial_out_o;
      p_oe_d    = primary_oe_o;
      s_out_d   = secondary_serial_out_o;
      s_oe_d    = secondary_oe_o;
      live      = 1'b0;
      clash     = 1'b0;
      h1        = 2'b00;
      h2        = 2'b00;
      b1        = 1'b0;
      b2        = 1'b0;
      slot      = 6'h00;
      frame_start = 1'b0;
      dly = CNT_W'(ofs) + ((fmt == FMT_I2S) ? CNT_W'(1) : CNT_W'(0));
      pos = CNT_W'(0);
      if (bclk_fall) begin
         fs_last_d = fs_s2_q;
         // A TDM sync pulse opens a frame on its rise only
         frame_start = (fmt == FMT_TDM) ? (fs_s2_q && !fs_last_q) : (fs_s2_q != fs_last_q);
         if (frame_start) begin
            cnt_d = CNT_W'(0);
            if ((fmt == FMT_I2S) ? !fs_s2_q : fs_s2_q) begin
               d1_d = chan1_data_i;
               d2_d = chan2_data_i;
            end
         end else if (cnt_q != CNT_MAX) begin
            cnt_d = cnt_q + CNT_W'(1);
         end
         case (fmt)
            FMT_I2S: right_d = fs_s2_q;
            FMT_LJ:  right_d = !fs_s2_q;
            default: right_d = 1'b0;
         endcase
         pos  = cnt_d - dly;
         live = (cnt_d >= dly) && ((pos >> SLOT_LG) < CNT_W'(ALL_SLOTS));
         slot = 6'(pos >> SLOT_LG);
         if (fmt != FMT_TDM) begin
            live = live && ((pos >> SLOT_LG) < CNT_W'(HALF_SLOTS));
            slot = {right_d, slot[4:0]};
         end
         if (live) begin
            cur_d = slot;
         end
         // Bits come from the word in force at this fall
         b1 = d1_d[SLOT_W - 1 - int'(pos[SLOT_LG-1:0])];
         b2 = d2_d[SLOT_W - 1 - int'(pos[SLOT_LG-1:0])];
         for (int l = 0; l < 2; l++) begin
            h1[l] = live && hits(ch1_q, l[0], slot);
            h2[l] = live && hits(ch2_q, l[0], slot);
         end
         clash = (h1[0] & h2[0]) | (h1[1] & h2[1]);
         p_oe_d  = h1[0] | h2[0];
         p_out_d = h1[0] ? b1 : (h2[0] & b2);
         s_oe_d  = h1[1] | h2[1];
         s_out_d = h1[1] ? b1 : (h2[1] & b2);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q                  <= CNT_MAX;
         fs_last_q              <= 1'b0;
         right_q                <= 1'b0;
         d1_q                   <= '0;
         d2_q                   <= '0;
         cur_q                  <= 6'h00;
         primary_serial_out_o   <= 1'b0;
         primary_oe_o           <= 1'b0;
         secondary_serial_out_o <= 1'b0;
         secondary_oe_o         <= 1'b0;
      end else begin
         cnt_q                  <= cnt_d;
         fs_last_q              <= fs_last_d;
         right_q                <= right_d;
         d1_q                   <= d1_d;
         d2_q                   <= d2_d;
         cur_q                  <= cur_d;
         primary_serial_out_o   <= p_out_d;
         primary_oe_o           <= p_oe_d;
         secondary_serial_out_o <= s_out_d;
         secondary_oe_o         <= s_oe_d;
      end
   end

   // Bus slave
   always_comb begin
      ch1_d  = ch1_q;
      ch2_d  = ch2_q;
      frm_d  = frm_q;
      conf_d = conf_q;
      ack_d  = cyc_i & stb_i & ~ack_o;
      dat_d  = 32'h0000_0000;
      if (wr_lane) begin
         if (idx == CH1_IDX) begin
            ch1_d = dat_i[6:0];
         end else if (idx == CH2_IDX) begin
            ch2_d = dat_i[6:0];
         end else if (idx == FRM_IDX) begin
            frm_d = dat_i[6:0];
         end else if (idx == STAT_IDX && dat_i[CONF_BIT]) begin
            conf_d = 1'b0;
         end
      end
      if (clash) begin
         conf_d = 1'b1;
      end
      if (ack_d && !we_i) begin
         if (idx == CH1_IDX) begin
            dat_d = {25'h000_0000, ch1_q};
         end else if (idx == CH2_IDX) begin
            dat_d = {25'h000_0000, ch2_q};
         end else if (idx == FRM_IDX) begin
            dat_d = {25'h000_0000, frm_q};
         end else if (idx == STAT_IDX) begin
            dat_d = {18'h0_0000, cur_q, 6'h00, fs_s2_q, conf_q};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ch1_q  <= CH1_RST;
         ch2_q  <= CH2_RST;
         frm_q  <= FRM_RST;
         conf_q <= 1'b0;
         ack_o  <= 1'b0;
         dat_o  <= 32'h0000_0000;
      end else begin
         ch1_q  <= ch1_d;
         ch2_q  <= ch2_d;
         frm_q  <= frm_d;
         conf_q <= conf_d;
         ack_o  <= ack_d;
         dat_o  <= dat_d;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ch1_primary: assert property (bclk_fall && h1[0] |=>
      primary_oe_o && primary_serial_out_o == $past(b1)) else $error("ch1 not on primary");
   a_ch2_secondary: assert property (bclk_fall && h2[1] && !h1[1] |=>
      secondary_oe_o && secondary_serial_out_o == $past(b2)) else $error("ch2 not on secondary");
   a_left_codes: assert property (bclk_fall && h1[0] && fmt != FMT_TDM && !right_d
      |-> ch1_q[5] == 1'b0) else $error("left slot with high code");
   a_right_codes: assert property (bclk_fall && (h2[0] | h2[1]) && right_d
      |-> ch2_q[5] == 1'b1) else $error("right slot with low code");
   a_ch1_reset: assert property ($fell(rst_i) |-> ch1_q == 7'h00)
      else $error("ch1 reset wrong");
   a_ch2_reset: assert property ($fell(rst_i) |-> ch2_q == 7'h01)
      else $error("ch2 reset wrong");
   a_bit7_zero: assert property (ack_o && !we_i |-> dat_o[7] == 1'b0)
      else $error("bit 7 not zero");
   a_slot_linear: assert property (bclk_fall && h1[0] |->
      ch1_q[5:0] == slot && cnt_d >= dly) else $error("slot map not linear");
   a_offset_idle: assert property (bclk_fall && cnt_d < dly |=>
      !primary_oe_o && !secondary_oe_o) else $error("drive before offset");
   a_clash_prio: assert property (bclk_fall && h1[0] && h2[0] |=>
      primary_serial_out_o == $past(b1) ##1 conf_q) else $error("clash not resolved");
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
   // Line choice, ch2 slot map, idle lines, sticky conflict and upper read bits
   a_ch1_secondary: assert property (bclk_fall && h1[1] |=>
      secondary_oe_o && secondary_serial_out_o == $past(b1)) else $error("ch1 off secondary");
   a_ch2_primary: assert property (bclk_fall && h2[0] && !h1[0] |=>
      primary_oe_o && primary_serial_out_o == $past(b2)) else $error("ch2 off primary");
   a_ch2_linear: assert property (bclk_fall && h2[1] |->
      ch2_q[5:0] == slot && cnt_d >= dly) else $error("chan2_slot_code map not linear");
   a_idle_primary: assert property (bclk_fall && !h1[0] && !h2[0] |=>
      !primary_oe_o && !primary_serial_out_o) else $error("primary drives idle");
   a_idle_secondary: assert property (bclk_fall && !h1[1] && !h2[1] |=>
      !secondary_oe_o && !secondary_serial_out_o) else $error("secondary drives idle");
   a_conf_sticky: assert property (conf_q && !(wr_lane && idx == STAT_IDX) |=> conf_q)
      else $error("conflict flag lost");
   a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:14] == 18'h0_0000)
      else $error("upper read bits not zero");
endmodule : audio_serial_slot_mapper
`default_nettype wire

//--- core/slot_map_pkg.sv
// Package: register map, fields, reset values and frame formats
// Assumes a 25 MHz system clock and a Wishbone slave with word-indexed registers
package slot_map_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] CH1_IDX  = 6'h0B;
   localparam logic [5:0] CH2_IDX  = 6'h0C;
   localparam logic [5:0] FRM_IDX  = 6'h10;
   localparam logic [5:0] STAT_IDX = 6'h11;
   // Reset values
   localparam logic [6:0] CH1_RST = 7'h00;
   localparam logic [6:0] CH2_RST = 7'h01;
   localparam logic [6:0] FRM_RST = 7'h00;
   // Field positions
   localparam int LINE_BIT  = 6;
   localparam int SLOT_HI   = 5;
   localparam int FMT_HI    = 1;
   localparam int OFS_LO    = 2;
   localparam int OFS_HI    = 6;
   localparam int CONF_BIT  = 0;
   localparam int FSYNC_BIT = 1;
   localparam int CUR_LO    = 8;
   // Slot numbering
   localparam int HALF_SLOTS = 32;
   localparam int ALL_SLOTS  = 64;
   typedef enum logic [1:0] {FMT_TDM, FMT_I2S, FMT_LJ} fmt_t;
endpackage : slot_map_pkg

//--- bench/host_model.sv
// Host model: bit clock, frame sync, slot word capture
// Assumes the mapper drives its lines after bit clock falls
`timescale 1ns/1ps
`default_nettype none
module host_model
   import slot_map_pkg::*;
#(parameter int SW = 8) (
   // Setup
   input  wire logic [1:0]     fmt_i,
   input  wire logic [4:0]     ofs_i,
   // Link
   output logic                bclk_o,
   output logic                fsync_o,
   input  wire logic [1:0]     d_i,
   input  wire logic [1:0]     oe_i,
   // Captured words
   output var int              frames_o,
   output logic [1:0]          vld_o,
   output logic [1:0][5:0]     slot_o,
   output logic [1:0][SW-1:0]  word_o
);
   int n = 0;
   int pn = 0;
   int p;
   logic [1:0] ok;
   logic [1:0][SW-1:0] sh;
   initial begin
      bclk_o = 1'b0;
      fsync_o = 1'b0;
      frames_o = 0;
      vld_o = 2'b00;
      #37;
      forever #160 bclk_o = ~bclk_o;
   end
   // Sync pulse in TDM, half frame level otherwise
   always @(posedge bclk_o) begin
      n = (n + 1) % 512;
      fsync_o <= (fmt_i == FMT_TDM) ? (n == 0) : ((fmt_i == FMT_I2S) == (n >= 256));
   end
   always @(negedge bclk_o) begin
      vld_o = 2'b00;
      if (n == 0) frames_o++;
      p = ((fmt_i == FMT_TDM) ? pn : pn % 256) - ofs_i - (fmt_i == FMT_I2S);
      for (int l = 0; l < 2; l++) begin
         if (p >= 0 && (fmt_i == FMT_TDM || p < 32 * SW)) begin
            ok[l] = (p % SW == 0 || ok[l]) && oe_i[l];
            sh[l] = {sh[l][SW-2:0], d_i[l]};
            if (p % SW == SW - 1 && ok[l]) begin
               vld_o[l] = 1'b1;
               slot_o[l] = 6'(p / SW + ((fmt_i != FMT_TDM && pn >= 256) ? 32 : 0));
               word_o[l] = sh[l];
            end
         end
      end
      pn = n;
   end
endmodule : host_model
`default_nettype wire

//--- bench/tb_top.sv
// Testbench: register accesses and frame scenarios, queued checks
// Assumes host_model makes the link and reports slot words
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import slot_map_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00, c1d = 8'h00, c2d = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000, dat_o;
   logic [1:0] fmt = 2'b00, vld, d, oe;
   logic [4:0] ofs = 5'h00;
   logic [6:0] v;
   logic [1:0][5:0] slot;
   logic [1:0][7:0] word;
   logic ack_o, bclk, fsync, arm = 1'b0;
   int frames, mismatches = 0, comparisons = 0, cycles = 0, seed = 32'h0064_bc32;
   logic [31:0] rq [$];
   logic [13:0] sq [2][$];
   always #20 clk_i = ~clk_i;
   audio_serial_slot_mapper #(.SLOT_W(8), .ADR_W(8)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .chan1_data_i(c1d), .chan2_data_i(c2d), .bclk_i(bclk), .fsync_i(fsync),
      .primary_serial_out_o(d[0]), .primary_oe_o(oe[0]),
      .secondary_serial_out_o(d[1]), .secondary_oe_o(oe[1]));
   host_model #(.SW(8)) host_u (.fmt_i(fmt), .ofs_i(ofs), .bclk_o(bclk), .fsync_o(fsync),
      .d_i(d), .oe_i(oe), .frames_o(frames), .vld_o(vld), .slot_o(slot), .word_o(word));
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim
   task automatic wb(input logic w, input logic [7:0] a, input logic [6:0] x, input logic s);
      @(posedge clk_i);
      // Bit 7 of write data stays zero
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, 25'h000_0000, x, 3'b000, s};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      {cyc_i, stb_i} <= 2'b00;
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      wb(1'b0, a, 7'h00, 1'b1);
   endtask : rd
   task automatic ft(input logic [6:0] a, input logic [6:0] b, input logic [1:0] f,
                     input logic [4:0] o);
      logic [7:0] w1;
      logic [7:0] w2;
      w1 = 8'($random(seed));
      w2 = 8'($random(seed));
      wb(1'b1, 8'h2C, a, 1'b1);
      wb(1'b1, 8'h30, b, 1'b1);
      wb(1'b1, 8'h40, {o, f}, 1'b1);
      {fmt, ofs, c1d, c2d} <= {f, o, w1, w2};
      repeat (2) @(frames);
      @(posedge bclk);
      #1 arm = 1'b1;
      if (b[5:0] < a[5:0]) sq[b[6]].push_back({b[5:0], w2});
      sq[a[6]].push_back({a[5:0], w1});
      if (b[5:0] > a[5:0] || (b[5:0] == a[5:0] && b[6] != a[6])) sq[b[6]].push_back({b[5:0], w2});
      @(frames);
      @(posedge bclk);
      #1 arm = 1'b0;
      comparisons++;
      if (sq[0].size() + sq[1].size() != 0) begin
         mismatches++;
         $display("unexpected at %0t: slot words missing", $time);
      end
      sq[0].delete();
      sq[1].delete();
      $display("frame test format %0d offset %0d done", f, o);
   endtask : ft
   // Timeout: a run past the ceiling counts as a mismatch
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 80000) begin
         mismatches++;
         end_sim();
      end
   end
   // Bus read answers
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0) begin
         comparisons++;
         if (rq.size() == 0 || dat_o !== rq[0]) begin
            mismatches++;
            $display("unexpected at %0t: read data %h", $time, dat_o);
         end
         if (rq.size() != 0) void'(rq.pop_front());
      end
   end
   // Slot words seen by the host
   always @(posedge bclk) begin
      for (int l = 0; l < 2; l++) begin
         if (vld[l] === 1'b1 && arm) begin
            comparisons++;
            if (sq[l].size() == 0 || {slot[l], word[l]} !== sq[l][0]) begin
               mismatches++;
               $display("unexpected at %0t: line %0d slot %0d word %h", $time, l, slot[l], word[l]);
            end
            if (sq[l].size() != 0) void'(sq[l].pop_front());
         end
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      v = 7'($random(seed));
      rd(8'h2C, 32'h0000_0000);
      rd(8'h30, 32'h0000_0001);
      wb(1'b1, 8'h2C, v, 1'b1);
      wb(1'b1, 8'h30, 7'h55, 1'b0);
      rd(8'h2C, {25'h000_0000, v});
      rd(8'h30, 32'h0000_0001);
      rd(8'h08, 32'h0000_0000);
      $display("register test done");
      ft(7'h5F, 7'h3E, 2'b00, 5'h00);
      ft(7'h05, 7'h65, 2'b01, 5'h00);
      ft(7'h7F, 7'h20, 2'b10, 5'h00);
      ft(7'h0A, 7'h0A, 2'b00, 5'h03);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
